// ===== core/vwu_cfg.svh
`ifndef VWU_CFG_SVH
`define VWU_CFG_SVH

// register word offsets (byte addresses)
`define VWU_OFS_CTRL     4'h0
`define VWU_OFS_ENABLE   4'h4
`define VWU_OFS_PRIO     4'h8
`define VWU_OFS_TRIG     4'hC

// control register fields
`define VWU_CTRL_GEN     0
`define VWU_CTRL_WDTRST  1
`define VWU_CTRL_SWREQ   2
`define VWU_CTRL_PEND_LSB 16

// trigger register fields
`define VWU_TRIG_A_LSB   0
`define VWU_TRIG_B_LSB   2
`define VWU_TRIG_C_LSB   4
`define VWU_TRIG_D_LSB   6
`define VWU_TRIG_NR_LSB  8

// reset values
`define VWU_CTRL_RST     3'h0
`define VWU_ENABLE_RST   12'h000
`define VWU_PRIO_RST     8'h00
`define VWU_TRIG_RST     10'h000

// source indices
`define VWU_SRC_A        0
`define VWU_SRC_B        1
`define VWU_SRC_C        2
`define VWU_SRC_TLO      3
`define VWU_SRC_D        4
`define VWU_SRC_BASE     5
`define VWU_SRC_THI      6
`define VWU_SRC_SLICE    7
`define VWU_SRC_VS       8
`define VWU_SRC_HS       9
`define VWU_SRC_TWI      10
`define VWU_SRC_SW       11

// vector addresses: base plus step per slot
`define VWU_VEC_BASE     8'h03
`define VWU_VEC_STEP     5'h08

// noise filter sample periods minus one (1, 16, 64 cycles)
`define VWU_NR_P1        6'h00
`define VWU_NR_P16       6'h0F
`define VWU_NR_P64       6'h3F

`endif

// ===== core/vwu_pkg.sv
package vwu_pkg;

  typedef enum logic [1:0] {
    VWU_BUS_IDLE = 2'b01,
    VWU_BUS_ACK  = 2'b10
  } vwu_bus_e;

  // 0 low, 1 high, 2 highest
  typedef logic [1:0] vwu_lvl_t;

  // trigger formats; a/b use all four, c/d use rise, fall, both
  typedef enum logic [1:0] {
    VWU_TRG_RISE = 2'h0,
    VWU_TRG_FALL = 2'h1,
    VWU_TRG_HI_BOTH = 2'h2,
    VWU_TRG_LOW  = 2'h3
  } vwu_trg_e;

endpackage : vwu_pkg

// ===== core/vwu_core.sv
// Our own choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "vwu_cfg.svh"
// Operation
// - twelve request sources are collected onto eight vector slots
// - slots one and two each serve only external pin a or b
// - slot three is shared by pin c and lower timer half overflow
// - slot four is shared by pin d and base timer overflow
// - slot five serves the upper timer half
// - slot six slicer, seven vertical/horizontal sync, eight two-wire bus and software
// - three levels; a higher level request preempts the one in service
// - slots three to eight are low or high, never highest
// - pins a and b are low or highest
// - pin a detects rise, fall, high or low level; vector 03H
// - pin b detects rise, fall, high or low level; vector 0BH
// - pin c detects rise, fall or both edges; vector 13H
// - pin d detects rise, fall or both edges; vector 1BH
// - pin d passes a noise filter before edge detection
// - pins c and d also serve as timer event count inputs
// - in halt, an accepted request ends the halt
// - in hold, only reset pin low or programmed level on a/b wakes
// - watchdog overflow raises an interrupt or a system reset by setting
module vwu_core
  import vwu_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // external pins
  input  wire logic        port7_bit0,
  input  wire logic        port7_bit1,
  input  wire logic        port7_bit2,
  input  wire logic        port7_bit3,
  input  wire logic        reset_pin_n,
  // on-chip request pulses
  input  wire logic        timer_low_half,
  input  wire logic        timer_high_half,
  input  wire logic        base_timer_ovf,
  input  wire logic        slicer_req,
  input  wire logic        vertical_sync_in,
  input  wire logic        horizontal_sync_in,
  input  wire logic        twi_req,
  input  wire logic        wdt_ovf,
  // cpu core
  input  wire logic        cpu_ack,
  input  wire logic        cpu_reti,
  input  wire logic        cpu_halt,
  input  wire logic        cpu_hold,
  output logic             cpu_irq,
  output logic      [7:0]  cpu_vector,
  output vwu_lvl_t         cpu_level,
  output logic             halt_release,
  output logic             hold_release,
  output logic             wdt_reset_req,
  output logic             timer_event_input
);

  localparam int NSRC = 12;
  localparam int NVEC = 8;

  //----------------------------------------------------------------
  // functions
  //----------------------------------------------------------------
  function automatic logic trig_ab(input logic [1:0] f, input logic lv,
                                   input logic ri, input logic fa);
    unique case (f)
      VWU_TRG_RISE:    trig_ab = ri;
      VWU_TRG_FALL:    trig_ab = fa;
      VWU_TRG_HI_BOTH: trig_ab = lv;
      default:         trig_ab = !lv;
    endcase
  endfunction : trig_ab

  function automatic logic trig_cd(input logic [1:0] f, input logic ri,
                                   input logic fa);
    unique case (f)
      VWU_TRG_RISE: trig_cd = ri;
      VWU_TRG_FALL: trig_cd = fa;
      default:      trig_cd = ri | fa;
    endcase
  endfunction : trig_cd

  function automatic vwu_lvl_t vec_lvl(input int v, input logic p);
    if (v < 2)
      vec_lvl = p ? 2'h2 : 2'h0;
    else
      vec_lvl = p ? 2'h1 : 2'h0;
  endfunction : vec_lvl

  //----------------------------------------------------------------
  // pin synchronisers and edges
  //----------------------------------------------------------------
  logic [4:0] pin_m_r;
  logic [4:0] pin_s_r;
  logic [3:0] pin_d_r;
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      pin_m_r <= 5'h10;
      pin_s_r <= 5'h10;
    end
    else
    begin
      pin_m_r <= {reset_pin_n, port7_bit3, port7_bit2, port7_bit1, port7_bit0};
      pin_s_r <= pin_m_r;
    end
  end

  // noise filter on pin d
  logic [1:0] nr_sel;
  logic [5:0] nr_cnt_r;
  logic       nr_tick;
  logic       nr_smp_r;
  logic       nr_filt_r;
  logic [5:0] nr_per;
  always_comb
  begin
    unique case (nr_sel)
      2'h1:    nr_per = `VWU_NR_P16;
      2'h2:    nr_per = `VWU_NR_P64;
      default: nr_per = `VWU_NR_P1;
    endcase
  end
  assign nr_tick = (nr_cnt_r == 6'h00);

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      nr_cnt_r <= 6'h00;
    else if (nr_tick)
      nr_cnt_r <= nr_per;
    else
      nr_cnt_r <= nr_cnt_r - 6'h01;
  end

  // level accepted only after two equal samples
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      nr_smp_r  <= 1'b0;
      nr_filt_r <= 1'b0;
    end
    else if (nr_tick)
    begin
      nr_smp_r <= pin_s_r[3];
      if (nr_smp_r == pin_s_r[3])
        nr_filt_r <= nr_smp_r;
    end
  end

  logic [3:0] pin_lv;
  logic [3:0] pin_ri;
  logic [3:0] pin_fa;
  assign pin_lv = {nr_filt_r, pin_s_r[2:0]};
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      pin_d_r <= 4'h0;
    else
      pin_d_r <= pin_lv;
  end
  assign pin_ri = pin_lv & ~pin_d_r;
  assign pin_fa = ~pin_lv & pin_d_r;

  //----------------------------------------------------------------
  // registers
  //----------------------------------------------------------------
  logic [2:0]      ctrl_r;
  logic [NSRC-1:0] en_r;
  logic [NVEC-1:0] prio_r;
  logic [9:0]      trig_r;
  logic [NSRC-1:0] pend_r;
  logic [2:0]      svc_r;
  vwu_bus_e        bus_st_r;
  logic            acc_wr;
  logic            sw_set;
  assign nr_sel = trig_r[`VWU_TRIG_NR_LSB +: 2];
  assign acc_wr = (bus_st_r == VWU_BUS_ACK) && avs_write;
  assign sw_set = acc_wr && (avs_address == `VWU_OFS_CTRL)
                  && avs_writedata[`VWU_CTRL_SWREQ];

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_r <= `VWU_CTRL_RST;
      en_r   <= `VWU_ENABLE_RST;
      prio_r <= `VWU_PRIO_RST;
      trig_r <= `VWU_TRIG_RST;
    end
    else if (acc_wr)
    begin
      unique case (avs_address)
        `VWU_OFS_CTRL:   ctrl_r <= {1'b0, avs_writedata[1:0]};
        `VWU_OFS_ENABLE: en_r   <= avs_writedata[NSRC-1:0];
        `VWU_OFS_PRIO:   prio_r <= avs_writedata[NVEC-1:0];
        `VWU_OFS_TRIG:   trig_r <= avs_writedata[9:0];
        default:         ;
      endcase
    end
  end

  //----------------------------------------------------------------
  // source pending flags
  //----------------------------------------------------------------
  logic [NSRC-1:0] src_set;
  logic [NSRC-1:0] pend_clr;
  logic            wdt_irq;
  assign wdt_irq = wdt_ovf && !ctrl_r[`VWU_CTRL_WDTRST];
  always_comb
  begin
    src_set = '0;
    src_set[`VWU_SRC_A]     = trig_ab(trig_r[`VWU_TRIG_A_LSB +: 2], pin_lv[0],
                                      pin_ri[0], pin_fa[0]);
    src_set[`VWU_SRC_B]     = trig_ab(trig_r[`VWU_TRIG_B_LSB +: 2], pin_lv[1],
                                      pin_ri[1], pin_fa[1]);
    src_set[`VWU_SRC_C]     = trig_cd(trig_r[`VWU_TRIG_C_LSB +: 2],
                                      pin_ri[2], pin_fa[2]);
    src_set[`VWU_SRC_D]     = trig_cd(trig_r[`VWU_TRIG_D_LSB +: 2],
                                      pin_ri[3], pin_fa[3]);
    src_set[`VWU_SRC_TLO]   = timer_low_half;
    src_set[`VWU_SRC_BASE]  = base_timer_ovf;
    src_set[`VWU_SRC_THI]   = timer_high_half;
    src_set[`VWU_SRC_SLICE] = slicer_req;
    src_set[`VWU_SRC_VS]    = vertical_sync_in;
    src_set[`VWU_SRC_HS]    = horizontal_sync_in;
    src_set[`VWU_SRC_TWI]   = twi_req;
    src_set[`VWU_SRC_SW]    = sw_set | wdt_irq;
  end
  // write-1-to-clear through the control word; a set in the same cycle wins
  assign pend_clr = (acc_wr && avs_address == `VWU_OFS_CTRL)
                    ? avs_writedata[`VWU_CTRL_PEND_LSB +: NSRC] : '0;

  genvar gs;
  generate
    for (gs = 0; gs < NSRC; gs++)
    begin : g_pend
      always_ff @(posedge sys_clk or posedge rst)
      begin
        if (rst)
          pend_r[gs] <= 1'b0;
        else if (src_set[gs])
          pend_r[gs] <= 1'b1;
        else if (pend_clr[gs])
          pend_r[gs] <= 1'b0;
      end
    end
  endgenerate

  //----------------------------------------------------------------
  // vector mapping and arbitration
  //----------------------------------------------------------------
  logic [NSRC-1:0] act;
  logic [NVEC-1:0] vec_req;
  assign act = pend_r & en_r;
  assign vec_req = {act[`VWU_SRC_TWI] | act[`VWU_SRC_SW],
                    act[`VWU_SRC_VS] | act[`VWU_SRC_HS],
                    act[`VWU_SRC_SLICE],
                    act[`VWU_SRC_THI],
                    act[`VWU_SRC_D] | act[`VWU_SRC_BASE],
                    act[`VWU_SRC_C] | act[`VWU_SRC_TLO],
                    act[`VWU_SRC_B],
                    act[`VWU_SRC_A]};

  logic [2:0]      svc_top;
  logic [NVEC-1:0] elig;
  logic            found;
  logic [2:0]      best_v;
  vwu_lvl_t        best_l;
  always_comb
  begin
    if (svc_r[2])
      svc_top = 3'h3;
    else if (svc_r[1])
      svc_top = 3'h2;
    else if (svc_r[0])
      svc_top = 3'h1;
    else
      svc_top = 3'h0;
  end

  always_comb
  begin
    found  = 1'b0;
    best_v = 3'h0;
    best_l = 2'h0;
    elig   = '0;
    for (int v = NVEC - 1; v >= 0; v--)
    begin
      elig[v] = vec_req[v] && ctrl_r[`VWU_CTRL_GEN]
                && ({1'b0, vec_lvl(v, prio_r[v])} + 3'h1 > svc_top);
      if (elig[v] && (!found || vec_lvl(v, prio_r[v]) >= best_l))
      begin
        found  = 1'b1;
        best_v = 3'(v);
        best_l = vec_lvl(v, prio_r[v]);
      end
    end
  end

  //----------------------------------------------------------------
  // dispatch and in-service levels
  //----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cpu_irq    <= 1'b0;
      cpu_vector <= `VWU_VEC_BASE;
      cpu_level  <= 2'h0;
    end
    else if (cpu_ack && cpu_irq)
      cpu_irq <= 1'b0;
    else
    begin
      cpu_irq    <= found;
      cpu_vector <= `VWU_VEC_BASE + {2'h0, best_v, 3'h0};
      cpu_level  <= best_l;
    end
  end

  logic [2:0] svc_nxt;
  always_comb
  begin
    svc_nxt = svc_r;
    if (cpu_reti)
    begin
      if (svc_r[2])
        svc_nxt[2] = 1'b0;
      else if (svc_r[1])
        svc_nxt[1] = 1'b0;
      else
        svc_nxt[0] = 1'b0;
    end
    if (cpu_ack && cpu_irq)
      svc_nxt[cpu_level] = 1'b1;
  end
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      svc_r <= 3'h0;
    else
      svc_r <= svc_nxt;
  end

  //----------------------------------------------------------------
  // standby wake, watchdog, timer events
  //----------------------------------------------------------------
  logic hold_a;
  logic hold_b;
  assign hold_a = trig_r[`VWU_TRIG_A_LSB] ? !pin_s_r[0] : pin_s_r[0];
  assign hold_b = trig_r[`VWU_TRIG_B_LSB] ? !pin_s_r[1] : pin_s_r[1];
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      halt_release      <= 1'b0;
      hold_release      <= 1'b0;
      wdt_reset_req     <= 1'b0;
      timer_event_input <= 1'b0;
    end
    else
    begin
      halt_release      <= cpu_halt && (|elig);
      hold_release      <= cpu_hold && (!pin_s_r[4] || (hold_a && en_r[`VWU_SRC_A])
                           || (hold_b && en_r[`VWU_SRC_B]));
      wdt_reset_req     <= wdt_ovf && ctrl_r[`VWU_CTRL_WDTRST];
      timer_event_input <= pin_ri[2] | pin_ri[3];
    end
  end

  //----------------------------------------------------------------
  // bus slave
  //----------------------------------------------------------------
  logic [31:0] rd_nxt;
  always_comb
  begin
    unique case (avs_address)
      `VWU_OFS_CTRL:   rd_nxt = {4'h0, pend_r, 13'h0, ctrl_r};
      `VWU_OFS_ENABLE: rd_nxt = {20'h0, en_r};
      `VWU_OFS_PRIO:   rd_nxt = {24'h0, prio_r};
      `VWU_OFS_TRIG:   rd_nxt = {22'h0, trig_r};
      default:         rd_nxt = 32'h0;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      bus_st_r        <= VWU_BUS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
    end
    else
    begin
      unique case (bus_st_r)
        VWU_BUS_IDLE:
        begin
          if (avs_read || avs_write)
          begin
            bus_st_r        <= VWU_BUS_ACK;
            avs_waitrequest <= 1'b0;
            avs_readdata    <= rd_nxt;
          end
        end
        VWU_BUS_ACK:
        begin
          bus_st_r        <= VWU_BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  //----------------------------------------------------------------
  // assertions
  //----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_req_seen;
    (avs_read || avs_write) && avs_waitrequest && bus_st_r == VWU_BUS_IDLE;
  endsequence
  sequence s_one_ack;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  a_bus_wait_one: assert property (s_req_seen |=> s_one_ack)
    else $error("waitrequest not low for exactly one cycle");
  a_pend_set_wins: assert property (|src_set |=>
    ((pend_r & $past(src_set)) == $past(src_set)))
    else $error("pending flag lost a set");
  a_pend_cleared: assert property (|(pend_clr & ~src_set) |=>
    ((pend_r & $past(pend_clr & ~src_set)) == '0))
    else $error("pending flag survived a clear");
  a_vec_addr_form: assert property (cpu_irq |->
    ((cpu_vector & 8'h07) == (`VWU_VEC_BASE & 8'h07)))
    else $error("vector address not on slot grid");
  a_highest_ab_only: assert property (cpu_irq && cpu_level == 2'h2 |->
    cpu_vector <= 8'h0B)
    else $error("highest level on a shared slot");
  a_nest_accept: assert property (cpu_ack && cpu_irq |=> svc_r[$past(cpu_level)])
    else $error("accepted level not marked in service");
  a_halt_wake: assert property (cpu_halt && (|elig) |=> halt_release)
    else $error("halt not released by request");
  a_hold_reset_wake: assert property (cpu_hold && !pin_s_r[4] |=> hold_release)
    else $error("hold not released by reset pin");
  a_wdt_choice: assert property (wdt_ovf |=>
    wdt_reset_req == $past(ctrl_r[`VWU_CTRL_WDTRST]))
    else $error("watchdog action wrong");
  a_filter_tick: assert property ($changed(nr_filt_r) |-> $past(nr_tick))
    else $error("filter changed off a sample tick");

endmodule : vwu_core

// ===== dv/vwu_cpu_model.sv
`timescale 1ns/1ps
module vwu_cpu_model
  import vwu_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // dispatch handshake
  input  wire logic       cpu_irq,
  input  wire logic [1:0] ack_dly,
  output logic            cpu_ack
);
  logic [1:0] wait_r;

  // ----------------------------------------
  // acceptance
  // ----------------------------------------
  // one ack pulse after a chosen delay; never two in a row
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cpu_ack <= 1'b0;
      wait_r  <= 2'h0;
    end
    else if (cpu_ack || !cpu_irq)
    begin
      cpu_ack <= 1'b0;
      wait_r  <= 2'h0;
    end
    else if (wait_r == ack_dly)
      cpu_ack <= 1'b1;
    else
      wait_r <= wait_r + 2'h1;
  end
endmodule : vwu_cpu_model

// ===== dv/tb.sv
`timescale 1ns/1ps
`include "vwu_cfg.svh"
module tb
  import vwu_pkg::*;
;
  logic        sys_clk;
  logic        rst;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [3:0]  pin;
  logic        reset_pin_n;
  logic [7:0]  pulse;
  logic        cpu_ack;
  logic        cpu_reti;
  logic        cpu_halt;
  logic        cpu_hold;
  logic        cpu_irq;
  logic [7:0]  cpu_vector;
  vwu_lvl_t    cpu_level;
  logic [3:0]  obs;
  logic [1:0]  ack_dly;
  logic        idle;
  logic        hl;
  logic [9:0]  exp_q [$];
  logic [31:0] rd_q [$];
  int          ev [4] = '{default: 0};
  int          snap [4];
  int          src_tbl [8] = '{3, 5, 6, 7, 8, 9, 10, 11};
  int          slot_tbl [8] = '{3, 4, 5, 6, 7, 7, 8, 8};
  int          en_tbl [4] = '{0, 1, 2, 4};
  int          fails = 0;
  int          n_tests = 0;
  int          seed = 77232;

  vwu_core u_dut (
    .sys_clk(sys_clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .port7_bit0(pin[0]), .port7_bit1(pin[1]), .port7_bit2(pin[2]), .port7_bit3(pin[3]),
    .reset_pin_n(reset_pin_n),
    .timer_low_half(pulse[0]), .base_timer_ovf(pulse[1]), .timer_high_half(pulse[2]),
    .slicer_req(pulse[3]), .vertical_sync_in(pulse[4]), .horizontal_sync_in(pulse[5]),
    .twi_req(pulse[6]), .wdt_ovf(pulse[7]),
    .cpu_ack(cpu_ack), .cpu_reti(cpu_reti), .cpu_halt(cpu_halt), .cpu_hold(cpu_hold),
    .cpu_irq(cpu_irq), .cpu_vector(cpu_vector), .cpu_level(cpu_level),
    .halt_release(obs[0]), .hold_release(obs[1]), .wdt_reset_req(obs[2]),
    .timer_event_input(obs[3])
  );

  vwu_cpu_model u_cpu (
    .sys_clk(sys_clk), .rst(rst), .cpu_irq(cpu_irq), .ack_dly(ack_dly), .cpu_ack(cpu_ack)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic tally_and_finish;
    if (fails == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp

  function automatic logic seen(input int i);
    return ev[i] != snap[i];
  endfunction : seen

  task automatic bus(input logic wr_en, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge sys_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr_en;
    avs_read      <= !wr_en;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (avs_waitrequest !== 1'b0 && k < 50);
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (k == 50)
      fails++;
  endtask : bus

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd

  task automatic expect_disp(input int slot, input vwu_lvl_t lvl);
    exp_q.push_back({lvl, 8'h03 + 8'(8 * (slot - 1))});
  endtask : expect_disp

  task automatic fire(input int b);
    @(posedge sys_clk);
    pulse[b] <= 1'b1;
    @(posedge sys_clk);
    pulse[b] <= 1'b0;
  endtask : fire

  task automatic settle;
    int k;
    k = 0;
    while (exp_q.size() != 0 && k < 60)
    begin
      @(posedge sys_clk);
      k++;
    end
    repeat (20) @(posedge sys_clk);
    cmp("dispatches owed", 0, exp_q.size());
  endtask : settle

  task automatic do_reset;
    rst         <= 1'b1;
    pin         <= 4'h0;
    pulse       <= 8'h00;
    cpu_halt    <= 1'b0;
    cpu_hold    <= 1'b0;
    cpu_reti    <= 1'b0;
    reset_pin_n <= 1'b1;
    ack_dly     <= 2'($random(seed));
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    snap = ev;
  endtask : do_reset

  // ----------------------------------------
  // clock, watchdog and monitors
  // ----------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  initial
  begin
    #2000000;
    fails++;
    tally_and_finish();
  end

  always @(posedge sys_clk)
  begin
    for (int i = 0; i < 4; i++)
      ev[i] <= ev[i] + int'(obs[i] === 1'b1);
    if (avs_read && avs_waitrequest === 1'b0)
      cmp("readdata", rd_q.pop_front(), avs_readdata);
    if (cpu_ack && cpu_irq === 1'b1)
      cmp("dispatch", exp_q.size() ? exp_q.pop_front() : 10'h3FF, {cpu_level, cpu_vector});
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    avs_address   <= 4'h0;
    avs_read      <= 1'b0;
    avs_write     <= 1'b0;
    avs_writedata <= 32'h0;
    do_reset();
    for (int i = 0; i < 4; i++)
      rd(4'(4 * i), 32'h0);
    wr(4'h6, 32'hFFFFFFFF);
    rd(4'h6, 32'h0);
    wr(`VWU_OFS_ENABLE, 32'hFFFFFFFF);
    wr(`VWU_OFS_PRIO, 32'hFFFFFFFF);
    wr(`VWU_OFS_TRIG, 32'h2F5);
    expect_disp(8, 2'h1);
    wr(`VWU_OFS_CTRL, 32'h7);
    rd(`VWU_OFS_ENABLE, 32'hFFF);
    rd(`VWU_OFS_PRIO, 32'hFF);
    rd(`VWU_OFS_TRIG, 32'h2F5);
    rd(`VWU_OFS_CTRL, 32'h08000003);
    settle();
    // on-chip sources onto slots three to eight
    for (int i = 0; i < 8; i++)
    begin
      do_reset();
      wr(`VWU_OFS_ENABLE, 32'(1) << src_tbl[i]);
      wr(`VWU_OFS_PRIO, 32'(i % 2) << (slot_tbl[i] - 1));
      wr(`VWU_OFS_CTRL, 32'h1);
      expect_disp(slot_tbl[i], 2'(i % 2));
      fire(i);
      settle();
      cmp("wdt_reset_req", 0, seen(2));
      rd(`VWU_OFS_CTRL, 32'h1 | (32'(1) << (16 + src_tbl[i])));
      wr(`VWU_OFS_CTRL, 32'h1 | (32'(1) << (16 + src_tbl[i])));
      rd(`VWU_OFS_CTRL, 32'h1);
    end
    // every trigger format of every pin
    for (int p = 0; p < 4; p++)
      for (int f = 0; f < 4; f++)
      begin
        if (p > 1 && f == 3)
          continue;
        do_reset();
        idle = (p < 2) ? f[0] : (f == 1);
        hl = (p < 2) && f[0];
        wr(`VWU_OFS_TRIG, 32'(f) << (2 * p));
        pin[p] <= idle;
        repeat (6) @(posedge sys_clk);
        wr(`VWU_OFS_CTRL, 32'h0FFF0000);
        wr(`VWU_OFS_PRIO, 32'(hl) << p);
        wr(`VWU_OFS_ENABLE, 32'(1) << en_tbl[p]);
        wr(`VWU_OFS_CTRL, 32'h1);
        expect_disp(p + 1, hl ? 2'h2 : 2'h0);
        @(posedge sys_clk);
        pin[p] <= !idle;
        settle();
        pin[p] <= idle;
        repeat (20) @(posedge sys_clk);
        if (p > 1)
          cmp("timer_event_input", 1, seen(3));
      end
    // noise filter at 16- and 64-cycle sampling
    for (int s = 1; s < 3; s++)
    begin
      int per;
      per = (s == 1) ? 16 : 64;
      do_reset();
      wr(`VWU_OFS_TRIG, 32'(s) << 8);
      wr(`VWU_OFS_ENABLE, 32'h10);
      wr(`VWU_OFS_CTRL, 32'h1);
      pin[3] <= 1'b1;
      repeat (per / 2) @(posedge sys_clk);
      pin[3] <= 1'b0;
      repeat (4 * per) @(posedge sys_clk);
      expect_disp(4, 2'h0);
      pin[3] <= 1'b1;
      repeat (3 * per) @(posedge sys_clk);
      pin[3] <= 1'b0;
      settle();
    end
    // tie, then preemption by higher levels
    do_reset();
    wr(`VWU_OFS_ENABLE, 32'hC9);
    wr(`VWU_OFS_PRIO, 32'h05);
    wr(`VWU_OFS_CTRL, 32'h1);
    expect_disp(5, 2'h0);
    @(posedge sys_clk);
    pulse <= 8'h0C;
    @(posedge sys_clk);
    pulse <= 8'h00;
    settle();
    expect_disp(3, 2'h1);
    fire(0);
    settle();
    expect_disp(1, 2'h2);
    pin[0] <= 1'b1;
    settle();
    // return level by level; the low slot left pending comes last
    wr(`VWU_OFS_CTRL, 32'h00490001);
    expect_disp(6, 2'h0);
    for (int i = 0; i < 3; i++)
    begin
      @(posedge sys_clk);
      cpu_reti <= 1'b1;
      @(posedge sys_clk);
      cpu_reti <= 1'b0;
    end
    settle();
    // halt wake
    do_reset();
    cpu_halt <= 1'b1;
    wr(`VWU_OFS_ENABLE, 32'h20);
    wr(`VWU_OFS_CTRL, 32'h1);
    cmp("halt_release", 0, seen(0));
    expect_disp(4, 2'h0);
    fire(1);
    settle();
    cmp("halt_release", 1, seen(0));
    // hold wake: pin c cannot, pin b low level can, with dispatch off
    do_reset();
    cpu_hold <= 1'b1;
    wr(`VWU_OFS_TRIG, 32'hC);
    pin[1] <= 1'b1;
    repeat (6) @(posedge sys_clk);
    wr(`VWU_OFS_ENABLE, 32'h6);
    pin[2] <= 1'b1;
    repeat (20) @(posedge sys_clk);
    cmp("hold_release", 0, seen(1));
    pin[1] <= 1'b0;
    repeat (20) @(posedge sys_clk);
    cmp("hold_release", 1, seen(1));
    do_reset();
    cpu_hold <= 1'b1;
    repeat (4) @(posedge sys_clk);
    reset_pin_n <= 1'b0;
    repeat (20) @(posedge sys_clk);
    cmp("hold_release", 1, seen(1));
    // watchdog in reset mode
    do_reset();
    wr(`VWU_OFS_ENABLE, 32'h800);
    wr(`VWU_OFS_CTRL, 32'h3);
    fire(7);
    settle();
    cmp("wdt_reset_req", 1, seen(2));
    tally_and_finish();
  end
endmodule : tb
